/* hdl/nvp_pkg.sv */
// Constants and types for the nonvolatile programming interface
package nvp_pkg;
    // Clock and self-timed write periods
    localparam int  CLK_KHZ        = 40000;
    localparam real T_WR_MAX_MS    = 4.5;
    localparam real T_CE_MAX_MS    = 9.0;
    // Longest times round down; both stay above their documented minimum
    localparam int  WR_CYC         = int'($floor(T_WR_MAX_MS * CLK_KHZ));
    localparam int  CE_CYC         = int'($floor(T_CE_MAX_MS * CLK_KHZ));
    localparam int  CNT_W          = 19;

    // Array geometry
    localparam int  FLASH_AW       = 10;
    localparam int  EE_AW          = 7;
    localparam int  PG_W           = 5;
    localparam int  PG_WORDS       = 32;
    localparam int  FLASH_WORDS    = 1024;
    localparam int  EE_BYTES       = 128;

    // Parallel action select {hi,lo} and byte select {high,low}
    localparam logic [1:0] AS_ADDR      = 2'b00;
    localparam logic [1:0] AS_DATA      = 2'b01;
    localparam logic [1:0] AS_CMD       = 2'b10;
    localparam logic [1:0] BSEL_FUSE_LO = 2'b00;
    localparam logic [1:0] BSEL_FUSE_HI = 2'b11;
    localparam logic [1:0] BSEL_FUSE_EX = 2'b10;
    localparam logic [1:0] BSEL_LOCK    = 2'b01;

    // Parallel command codes
    localparam logic [7:0] PC_FLASH_RD  = 8'h02;
    localparam logic [7:0] PC_EE_RD     = 8'h03;
    localparam logic [7:0] PC_FUSE_RD   = 8'h04;
    localparam logic [7:0] PC_SIG_RD    = 8'h08;
    localparam logic [7:0] PC_FLASH_WR  = 8'h10;
    localparam logic [7:0] PC_EE_WR     = 8'h11;
    localparam logic [7:0] PC_LOCK_WR   = 8'h20;
    localparam logic [7:0] PC_FUSE_WR   = 8'h40;
    localparam logic [7:0] PC_ERASE     = 8'h80;

    // Serial instruction bytes
    localparam logic [7:0] SI_ENABLE    = 8'hac;
    localparam logic [7:0] SI_SYNC      = 8'h53;
    localparam logic [7:0] SI_RD_FLASH  = 8'h20;
    localparam logic [7:0] SI_RD_SIG    = 8'h30;
    localparam logic [7:0] SI_LD_PAGE   = 8'h40;
    localparam logic [7:0] SI_WR_PAGE   = 8'h4c;
    localparam logic [7:0] SI_RD_FUSE   = 8'h50;
    localparam logic [7:0] SI_RD_LOCK   = 8'h58;
    localparam logic [7:0] SI_RD_EE     = 8'ha0;
    localparam logic [7:0] SI_WR_EE     = 8'hc0;
    localparam logic [2:0] SI_B2_ERASE  = 3'b100;
    localparam logic [2:0] SI_B2_LOCK   = 3'b111;
    localparam logic [7:0] SI_B2_FUSELO = 8'ha0;
    localparam logic [7:0] SI_B2_FUSEHI = 8'ha8;
    localparam logic [7:0] SI_B2_FUSEEX = 8'ha4;
    localparam int         SI_HI_BIT    = 27;

    // Reset values of fuses and locks; identity bytes are arbitrary
    localparam logic [7:0] FUSE_LO_RST  = 8'hff;
    localparam logic [7:0] FUSE_HI_RST  = 8'hff;
    localparam logic [7:0] FUSE_EX_RST  = 8'hff;
    localparam logic [7:0] LOCK_RST     = 8'hff;
    localparam logic [7:0] ERASED       = 8'hff;
    localparam logic [7:0] SIG_B0       = 8'h11;
    localparam logic [7:0] SIG_B1       = 8'h22;
    localparam logic [7:0] SIG_B2       = 8'h33;
    localparam logic [7:0] CAL_BYTE     = 8'h5a;

    typedef enum logic [2:0] {
        OP_FLASH_PAGE, OP_EE_SER, OP_EE_PAR, OP_FUSE_LO, OP_FUSE_HI, OP_FUSE_EX, OP_LOCK, OP_ERASE
    } nvp_op_e;

    typedef struct packed {
        nvp_op_e             kind;
        logic [FLASH_AW-1:0] addr;
        logic [7:0]          data;
    } nvp_wr_op_s;

    typedef struct packed {
        logic       par_mode;
        logic       oe_n;
        logic       wr_n;
        logic       load_strobe_pin;
        logic       action_select_hi;
        logic       action_select_lo;
        logic       byte_select_high;
        logic       byte_select_low;
        logic       page_latch_strobe;
        logic [7:0] data;
    } nvp_par_pins_s;

    localparam nvp_par_pins_s PAR_IDLE = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00};

    typedef struct packed {
        logic        en;
        logic [31:0] w;
    } nvp_ser_cmd_s;
endpackage

/* hdl/nvp_top.sv */
// Parallel and serial programming access to flash, EEPROM, fuses and locks
`timescale 1ns/1ps
`default_nettype none
module nvp_top #(
    parameter int WR_CYCLES = nvp_pkg::WR_CYC,
    parameter int CE_CYCLES = nvp_pkg::CE_CYC
) (
    input  wire logic                  clk_sys,
    input  wire logic                  nrst,
    input  wire nvp_pkg::nvp_par_pins_s par_in,
    output logic [7:0]                 par_data_out,
    output logic                       par_data_oe,
    output logic                       ready_busy_line,
    input  wire logic                  device_reset_n,
    input  wire logic                  sck,
    input  wire logic                  mosi,
    output logic                       miso,
    output logic                       miso_oe
);
    import nvp_pkg::*;

    localparam int PP_W = $bits(nvp_par_pins_s);

    // Storage
    logic [15:0]       flash_r [FLASH_WORDS];
    logic [7:0]        ee_r    [EE_BYTES];
    logic [15:0]       page_r  [PG_WORDS];
    logic [7:0]        fuse_lo_r;
    logic [7:0]        fuse_hi_r;
    logic [7:0]        fuse_ex_r;
    logic [7:0]        lock_r;

    // Write engine
    nvp_wr_op_s        op_r;
    nvp_wr_op_s        new_op;
    logic              new_go;
    logic              busy_r;
    logic [CNT_W-1:0]  cnt_r;
    logic              commit;

    // Parallel pin synchroniser, two agreeing stages qualify a change
    logic [PP_W-1:0]   ps1_r;
    logic [PP_W-1:0]   ps2_r;
    logic [PP_W-1:0]   ps3_r;
    logic [PP_W-1:0]   pf_r;
    logic [PP_W-1:0]   pd_r;
    nvp_par_pins_s     pf;
    nvp_par_pins_s     pd;
    logic              load_rise;
    logic              latch_rise;
    logic              wr_fall;
    logic [7:0]        pcmd_r;
    logic [15:0]       paddr_r;
    logic [15:0]       pdata_r;
    logic [7:0]        par_rd;

    // Serial clock domain
    logic [4:0]        bit_cnt_r;
    logic [31:0]       sh_r;
    logic [31:0]       sh_nxt;
    logic [23:0]       hdr_r;
    nvp_ser_cmd_s      cmd_r;
    logic              en_r;
    logic              tog_hdr_r;
    logic              tog_cmd_r;
    logic [7:0]        out_r;

    // Crossing into clk_sys
    logic [2:0]        ts1_r;
    logic [2:0]        ts2_r;
    logic [2:0]        ts3_r;
    logic [2:0]        tf_r;
    logic [2:0]        td_r;
    logic              ser_on;
    logic              hdr_ev;
    logic              cmd_ev;
    logic              ser_cmd;
    logic [7:0]        rd_data_r;

    function automatic logic in_prog_page(input logic [FLASH_AW-1:0] a);
        in_prog_page = busy_r && (op_r.kind == OP_ERASE ||
                       (op_r.kind == OP_FLASH_PAGE && a[FLASH_AW-1:PG_W] == op_r.addr[FLASH_AW-1:PG_W]));
    endfunction

    function automatic logic [7:0] flash_rd(input logic [FLASH_AW-1:0] a, input logic hi);
        logic [15:0] w;
        w = flash_r[a];
        if (in_prog_page(a)) begin
            flash_rd = ERASED;
        end else begin
            flash_rd = hi ? w[15:8] : w[7:0];
        end
    endfunction

    function automatic logic [7:0] ee_rd(input logic [EE_AW-1:0] a);
        if (busy_r && (op_r.kind == OP_ERASE ||
                       ((op_r.kind == OP_EE_SER || op_r.kind == OP_EE_PAR) && op_r.addr[EE_AW-1:0] == a))) begin
            ee_rd = ERASED;
        end else begin
            ee_rd = ee_r[a];
        end
    endfunction

    function automatic logic [7:0] sig_rd(input logic [1:0] i);
        case (i)
            2'd0:    sig_rd = SIG_B0;
            2'd1:    sig_rd = SIG_B1;
            2'd2:    sig_rd = SIG_B2;
            default: sig_rd = 8'h00;
        endcase
    endfunction

    // ---------------- Parallel side ----------------
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ps1_r <= PAR_IDLE;
            ps2_r <= PAR_IDLE;
            ps3_r <= PAR_IDLE;
            pf_r  <= PAR_IDLE;
            pd_r  <= PAR_IDLE;
        end else begin
            ps1_r <= par_in;
            ps2_r <= ps1_r;
            ps3_r <= ps2_r;
            pf_r  <= (ps2_r & ~(ps2_r ^ ps3_r)) | (pf_r & (ps2_r ^ ps3_r));
            pd_r  <= pf_r;
        end
    end

    assign pf         = nvp_par_pins_s'(pf_r);
    assign pd         = nvp_par_pins_s'(pd_r);
    assign load_rise  = pf.par_mode && pf.load_strobe_pin && !pd.load_strobe_pin;
    assign latch_rise = pf.par_mode && pf.page_latch_strobe && !pd.page_latch_strobe;
    assign wr_fall    = pf.par_mode && !pf.wr_n && pd.wr_n;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pcmd_r  <= 8'h00;
            paddr_r <= 16'h0000;
            pdata_r <= 16'h0000;
        end else if (load_rise) begin
            case ({pf.action_select_hi, pf.action_select_lo})
                AS_CMD:  pcmd_r <= pf.data;
                AS_ADDR: begin
                    if (pf.byte_select_low) begin
                        paddr_r[15:8] <= pf.data;
                    end else begin
                        paddr_r[7:0] <= pf.data;
                    end
                end
                AS_DATA: begin
                    if (pf.byte_select_low) begin
                        pdata_r[15:8] <= pf.data;
                    end else begin
                        pdata_r[7:0] <= pf.data;
                    end
                end
                default: pcmd_r <= pcmd_r;
            endcase
        end
    end

    always_comb begin
        par_rd = ERASED;
        case (pcmd_r)
            PC_FUSE_RD: begin
                case ({pf.byte_select_high, pf.byte_select_low})
                    BSEL_FUSE_LO: par_rd = fuse_lo_r;
                    BSEL_FUSE_HI: par_rd = fuse_hi_r;
                    BSEL_FUSE_EX: par_rd = fuse_ex_r;
                    default:      par_rd = lock_r;
                endcase
            end
            PC_SIG_RD: begin
                if (pf.byte_select_low) begin
                    par_rd = (paddr_r[7:0] == 8'h00) ? CAL_BYTE : 8'h00;
                end else begin
                    par_rd = (paddr_r[7:2] == 6'h00) ? sig_rd(paddr_r[1:0]) : 8'h00;
                end
            end
            PC_FLASH_RD: par_rd = flash_rd(paddr_r[FLASH_AW-1:0], pf.byte_select_low);
            PC_EE_RD:    par_rd = ee_rd(paddr_r[EE_AW-1:0]);
            default:     par_rd = ERASED;
        endcase
    end

    // Data and enable both registered so they move together
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            par_data_out <= 8'h00;
            par_data_oe  <= 1'b0;
        end else begin
            par_data_out <= par_rd;
            par_data_oe  <= pf.par_mode && !pf.oe_n;
        end
    end

    // ---------------- Serial clock domain ----------------
    assign sh_nxt = {sh_r[30:0], mosi};

    // Reset pin high clears the whole serial front end
    always_ff @(posedge sck or posedge device_reset_n) begin
        if (device_reset_n) begin
            bit_cnt_r <= 5'h00;
            sh_r      <= 32'h0000_0000;
            hdr_r     <= 24'h00_0000;
            cmd_r     <= '0;
            en_r      <= 1'b0;
            tog_hdr_r <= 1'b0;
            tog_cmd_r <= 1'b0;
        end else begin
            sh_r      <= sh_nxt;
            bit_cnt_r <= bit_cnt_r + 5'h01;
            if (bit_cnt_r == 5'd23) begin
                hdr_r     <= sh_nxt[23:0];
                tog_hdr_r <= ~tog_hdr_r;
            end
            if (bit_cnt_r == 5'd31) begin
                cmd_r     <= '{en: en_r, w: sh_nxt};
                tog_cmd_r <= ~tog_cmd_r;
                if (sh_nxt[31:24] == SI_ENABLE && sh_nxt[23:16] == SI_SYNC) begin
                    en_r <= 1'b1;
                end
            end
        end
    end

    // Read data is loaded at bit 24 after the header event, then shifted out on each falling sck edge
    always_ff @(negedge sck or posedge device_reset_n) begin
        if (device_reset_n) begin
            out_r <= 8'h00;
        end else if (bit_cnt_r == 5'd16) begin
            out_r <= (sh_r[15:8] == SI_ENABLE) ? sh_r[7:0] : 8'h00;
        end else if (bit_cnt_r == 5'd24) begin
            out_r <= rd_data_r;
        end else begin
            out_r <= {out_r[6:0], 1'b0};
        end
    end

    assign miso    = out_r[7];
    // serial output only while reset pin is low
    assign miso_oe = !device_reset_n;

    // ---------------- Crossing to clk_sys ----------------
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ts1_r <= 3'b000;
            ts2_r <= 3'b000;
            ts3_r <= 3'b000;
            tf_r  <= 3'b000;
            td_r  <= 3'b000;
        end else begin
            ts1_r <= {!device_reset_n, tog_cmd_r, tog_hdr_r};
            ts2_r <= ts1_r;
            ts3_r <= ts2_r;
            tf_r  <= (ts2_r & ~(ts2_r ^ ts3_r)) | (tf_r & (ts2_r ^ ts3_r));
            td_r  <= tf_r;
        end
    end

    assign ser_on  = tf_r[2];
    assign hdr_ev  = ser_on && (tf_r[0] ^ td_r[0]);
    assign cmd_ev  = ser_on && (tf_r[1] ^ td_r[1]);
    assign ser_cmd = cmd_ev && cmd_r.en && !busy_r;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rd_data_r <= 8'h00;
        end else if (hdr_ev) begin
            case (hdr_r[23:16])
                SI_RD_FLASH, SI_RD_FLASH | 8'h08: begin
                    rd_data_r <= flash_rd({hdr_r[9:8], hdr_r[7:0]}, hdr_r[19]);
                end
                SI_RD_EE:   rd_data_r <= ee_rd(hdr_r[EE_AW-1:0]);
                SI_RD_LOCK: rd_data_r <= lock_r;
                SI_RD_FUSE: rd_data_r <= fuse_lo_r;
                SI_RD_SIG:  rd_data_r <= sig_rd(hdr_r[1:0]);
                default:    rd_data_r <= 8'h00;
            endcase
        end
    end

    // ---------------- Write requests ----------------
    always_comb begin
        new_go = 1'b0;
        new_op = '{kind: OP_EE_PAR, addr: '0, data: pdata_r[7:0]};
        if (wr_fall) begin
            new_go      = 1'b1;
            new_op.addr = paddr_r[FLASH_AW-1:0];
            case (pcmd_r)
                PC_FLASH_WR: new_op.kind = OP_FLASH_PAGE;
                PC_EE_WR:    new_op.kind = OP_EE_PAR;
                PC_LOCK_WR:  new_op.kind = OP_LOCK;
                PC_ERASE:    new_op.kind = OP_ERASE;
                PC_FUSE_WR: begin
                    case ({pf.byte_select_high, pf.byte_select_low})
                        BSEL_FUSE_HI, BSEL_LOCK: new_op.kind = OP_FUSE_HI;
                        BSEL_FUSE_EX:            new_op.kind = OP_FUSE_EX;
                        default:                 new_op.kind = OP_FUSE_LO;
                    endcase
                end
                default:     new_go = 1'b0;
            endcase
        end else if (ser_cmd) begin
            new_go      = 1'b1;
            new_op.data = cmd_r.w[7:0];
            case (cmd_r.w[31:24])
                SI_WR_PAGE: begin
                    new_op.kind = OP_FLASH_PAGE;
                    new_op.addr = {cmd_r.w[17:16], cmd_r.w[15:13], 5'h00};
                end
                SI_WR_EE: begin
                    new_op.kind = OP_EE_SER;
                    new_op.addr = {3'b000, cmd_r.w[14:8]};
                end
                SI_ENABLE: begin
                    if (cmd_r.w[23:21] == SI_B2_ERASE) begin
                        new_op.kind = OP_ERASE;
                    end else if (cmd_r.w[23:21] == SI_B2_LOCK) begin
                        new_op.kind = OP_LOCK;
                        new_op.data = {2'b11, cmd_r.w[5:0]};
                    end else if (cmd_r.w[23:16] == SI_B2_FUSELO) begin
                        new_op.kind = OP_FUSE_LO;
                    end else if (cmd_r.w[23:16] == SI_B2_FUSEHI) begin
                        new_op.kind = OP_FUSE_HI;
                    end else if (cmd_r.w[23:16] == SI_B2_FUSEEX) begin
                        new_op.kind = OP_FUSE_EX;
                    end else begin
                        new_go = 1'b0;
                    end
                end
                default:    new_go = 1'b0;
            endcase
        end
    end

    assign commit = busy_r && (cnt_r == '0);

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            busy_r <= 1'b0;
            cnt_r  <= '0;
            op_r   <= '{kind: OP_EE_PAR, addr: '0, data: 8'h00};
        end else if (busy_r) begin
            busy_r <= !commit;
            cnt_r  <= commit ? cnt_r : cnt_r - 1'b1;
        end else if (new_go) begin
            busy_r <= 1'b1;
            op_r   <= new_op;
            cnt_r  <= (new_op.kind == OP_ERASE) ? CNT_W'(CE_CYCLES - 1) : CNT_W'(WR_CYCLES - 1);
        end
    end

    assign ready_busy_line = !busy_r;

    // Page buffer; freed back to blank once its page is committed
    always_ff @(posedge clk_sys) begin
        if (!nrst || (commit && op_r.kind == OP_FLASH_PAGE)) begin
            for (int i = 0; i < PG_WORDS; i++) begin
                page_r[i] <= {ERASED, ERASED};
            end
        end else if (latch_rise) begin
            page_r[paddr_r[PG_W-1:0]] <= pdata_r;
        // low and high byte per word index
        end else if (ser_cmd && (cmd_r.w[31:24] & ~8'h08) == SI_LD_PAGE) begin
            if (cmd_r.w[SI_HI_BIT]) begin
                page_r[cmd_r.w[PG_W+7:8]][15:8] <= cmd_r.w[7:0];
            end else begin
                page_r[cmd_r.w[PG_W+7:8]][7:0] <= cmd_r.w[7:0];
            end
        end
    end

    // Arrays start blank; flash and parallel EEPROM writes only clear bits
    always_ff @(posedge clk_sys) begin
        if (!nrst || (commit && op_r.kind == OP_ERASE)) begin
            for (int i = 0; i < FLASH_WORDS; i++) begin
                flash_r[i] <= {ERASED, ERASED};
            end
            for (int i = 0; i < EE_BYTES; i++) begin
                ee_r[i] <= ERASED;
            end
        end else if (commit) begin
            case (op_r.kind)
                OP_FLASH_PAGE: begin
                    for (int i = 0; i < PG_WORDS; i++) begin
                        flash_r[{op_r.addr[FLASH_AW-1:PG_W], PG_W'(i)}] <=
                            flash_r[{op_r.addr[FLASH_AW-1:PG_W], PG_W'(i)}] & page_r[i];
                    end
                end
                OP_EE_SER: ee_r[op_r.addr[EE_AW-1:0]] <= op_r.data;
                OP_EE_PAR: ee_r[op_r.addr[EE_AW-1:0]] <= ee_r[op_r.addr[EE_AW-1:0]] & op_r.data;
                default:   ee_r[0] <= ee_r[0];
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            fuse_lo_r <= FUSE_LO_RST;
            fuse_hi_r <= FUSE_HI_RST;
            fuse_ex_r <= FUSE_EX_RST;
            lock_r    <= LOCK_RST;
        end else if (commit) begin
            case (op_r.kind)
                OP_FUSE_LO: fuse_lo_r <= op_r.data;
                OP_FUSE_HI: fuse_hi_r <= op_r.data;
                OP_FUSE_EX: fuse_ex_r <= op_r.data;
                OP_LOCK:    lock_r    <= lock_r & op_r.data;
                OP_ERASE:   lock_r    <= LOCK_RST;
                default:    lock_r    <= lock_r;
            endcase
        end
    end
endmodule
`default_nettype wire

/* verif/nvp_prog_model.sv */
// Serial programmer model
`timescale 1ns/1ps
`default_nettype none
module nvp_prog_model (
    output logic      sck,
    output logic      mosi,
    input  wire logic miso
);
    initial sck = 1'b0;
    initial mosi = 1'b0;
    task automatic xfer(input logic [31:0] w, output logic [31:0] r);
        for (int i = 31; i >= 0; i--) begin
            mosi = w[i];
            #100 sck = 1'b1;
            r[i] = miso;
            #(i == 8 ? 300 : 100) sck = 1'b0;
        end
        mosi = ~mosi;
    endtask
endmodule
`default_nettype wire

/* verif/nvp_top_asserts.sv */
// Port checker for the programming block
`timescale 1ns/1ps
`default_nettype none
module nvp_top_asserts #(parameter int WR_CYCLES = 40, parameter int CE_CYCLES = 80) (
    input wire logic                   clk_sys,
    input wire logic                   nrst,
    input wire nvp_pkg::nvp_par_pins_s par_in,
    input wire logic [7:0]             par_data_out,
    input wire logic                   par_data_oe,
    input wire logic                   ready_busy_line,
    input wire logic                   device_reset_n,
    input wire logic                   sck,
    input wire logic                   miso,
    input wire logic                   miso_oe
);
    import nvp_pkg::*;
    logic [31:0] busy_r;
    always_ff @(posedge clk_sys)
        busy_r <= (!nrst || ready_busy_line) ? 32'h0 : busy_r + 32'h1;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    a_busy_len: assert property ($rose(ready_busy_line) |-> busy_r inside {WR_CYCLES, CE_CYCLES})
        else $error("busy length");
    a_busy_cause: assert property ((par_in.wr_n && device_reset_n)[*8] ##0 ready_busy_line |=> ready_busy_line)
        else $error("busy unprompted");
    a_oe_release: assert property (par_in.oe_n[*8] |-> !par_data_oe)
        else $error("bus held");
    a_oe_mode: assert property (!par_in.par_mode[*8] |-> !par_data_oe)
        else $error("bus driven");
    a_data_hold: assert property ((par_data_oe && ready_busy_line && $stable(par_in))[*8] |-> $stable(par_data_out))
        else $error("data moved");
    a_reset_out: assert property ($rose(nrst) |-> ready_busy_line && !par_data_oe && par_data_out == 8'h00)
        else $error("reset outputs");
    a_miso_en: assert property (miso_oe == !device_reset_n)
        else $error("miso enable");
    a_miso_fall: assert property ($changed(miso) |-> !sck || device_reset_n || $past(device_reset_n))
        else $error("miso edge");
endmodule
bind nvp_top nvp_top_asserts #(.WR_CYCLES(WR_CYCLES), .CE_CYCLES(CE_CYCLES)) chk (
    .clk_sys(clk_sys), .nrst(nrst), .par_in(par_in), .par_data_out(par_data_out), .par_data_oe(par_data_oe),
    .ready_busy_line(ready_busy_line), .device_reset_n(device_reset_n), .sck(sck), .miso(miso), .miso_oe(miso_oe));
`default_nettype wire

/* verif/nvp_top_test.sv */
// Bench for the programming block
`timescale 1ns/1ps
`default_nettype none
module nvp_top_test;
    import nvp_pkg::*;
    localparam logic [25:0] ROWS [8] = '{{PC_FUSE_RD, 8'h0, BSEL_FUSE_LO, FUSE_LO_RST},
        {PC_FUSE_RD, 8'h0, BSEL_FUSE_HI, FUSE_HI_RST}, {PC_FUSE_RD, 8'h0, BSEL_FUSE_EX, FUSE_EX_RST},
        {PC_FUSE_RD, 8'h0, BSEL_LOCK, LOCK_RST}, {PC_SIG_RD, 8'h0, 2'h0, SIG_B0}, {PC_SIG_RD, 8'h1, 2'h0, SIG_B1},
        {PC_SIG_RD, 8'h2, 2'h0, SIG_B2}, {PC_SIG_RD, 8'h0, 2'h1, CAL_BYTE}};
    logic clk_sys = 1'b0, nrst = 1'b0, rst_n = 1'b0, pdoe, rdy, sck, mosi, miso;
    logic [7:0] pdo;
    logic [31:0] rx;
    nvp_par_pins_s par_in = PAR_IDLE;
    int num_errors = 0, total_checks = 0, cyc = 0;
    nvp_top #(.WR_CYCLES(40), .CE_CYCLES(80)) dut (.clk_sys(clk_sys), .nrst(nrst), .par_in(par_in),
        .par_data_out(pdo), .par_data_oe(pdoe), .ready_busy_line(rdy), .device_reset_n(rst_n),
        .sck(sck), .mosi(mosi), .miso(miso), .miso_oe());
    nvp_prog_model prog (.sck(sck), .mosi(mosi), .miso(miso));
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (++cyc == 10000) wrap_up(1);
    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        num_errors += int'(g !== e);
        if (g !== e) $display("unexpected %s exp %h got %h", n, e, g);
    endtask
    task automatic pin(input logic o, input logic l, input logic [1:0] a, input logic [1:0] b, input logic [7:0] d);
        par_in <= '{1'b1, o, 1'b1, l, a[1], a[0], b[1], b[0], 1'b0, d};
        repeat (10) @(posedge clk_sys);
    endtask
    task automatic prd(input logic [25:0] r);
        for (int k = 0; k < 6; k++) pin(1'b1, k % 3 == 1, {k < 3, 1'b0}, 2'h0, r[25 - 8 * (k / 3) -: 8]);
        pin(1'b0, 1'b0, AS_DATA, r[9:8], 8'h0);
        chk8("read", r[7:0], pdoe ? pdo : 8'hzz);
        pin(1'b1, 1'b0, AS_DATA, r[9:8], 8'h0);
    endtask
    task automatic sx(input logic [31:0] w, input logic b);
        prog.xfer(w, rx);
        repeat (10) @(posedge clk_sys);
        // Look between edges so the busy flop has settled
        @(negedge clk_sys);
        chk8("busy", {7'h0, b}, {7'h0, !rdy});
        while (rdy !== 1'b1) @(posedge clk_sys);
        @(posedge clk_sys);
    endtask
    task automatic wrap_up(input int t);
        num_errors += t;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        // reset pin pulsed high, serial clock low
        @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (9) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (10) @(posedge clk_sys);
        foreach (ROWS[i]) prd(ROWS[i]);
        rst_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        sx({SI_WR_EE, 24'h00053c}, 1'b0);
        sx({SI_ENABLE, SI_SYNC, 16'h0}, 1'b0);
        chk8("echo", SI_SYNC, rx[15:8]);
        if (rx[15:8] !== SI_SYNC) begin
            rst_n <= 1'b1;
            repeat (4) @(posedge clk_sys);
            rst_n <= 1'b0;
            sx({SI_ENABLE, SI_SYNC, 16'h0}, 1'b0);
        end
        sx({SI_WR_EE, 24'h00053c}, 1'b1);
        sx({SI_WR_EE, 24'h0005c3}, 1'b1);
        sx({SI_RD_EE, 24'h000500}, 1'b0);
        chk8("eeprom", 8'hc3, rx[7:0]);
        sx({SI_LD_PAGE, 16'h0003, 8'h34}, 1'b0);
        sx({SI_LD_PAGE | 8'h08, 16'h0003, 8'h12}, 1'b0);
        sx({SI_WR_PAGE, 24'h000000}, 1'b1);
        sx({SI_RD_FLASH | 8'h08, 24'h000300}, 1'b0);
        chk8("flash high", 8'h12, rx[7:0]);
        sx({SI_RD_FLASH, 24'h000300}, 1'b0);
        chk8("flash low", 8'h34, rx[7:0]);
        sx({SI_ENABLE, SI_B2_FUSELO, 16'h12}, 1'b1);
        sx({SI_ENABLE, SI_B2_ERASE, 21'h0}, 1'b1);
        sx({SI_RD_EE, 24'h000500}, 1'b0);
        chk8("erased", ERASED, rx[7:0]);
        sx({SI_RD_FLASH | 8'h08, 24'h000300}, 1'b0);
        chk8("erased flash", ERASED, rx[7:0]);
        rst_n <= 1'b1;
        prd({PC_FUSE_RD, 8'h0, BSEL_FUSE_LO, 8'h12});
        nrst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        prd(ROWS[0]);
        wrap_up(0);
    end
endmodule
`default_nettype wire
